/* design/mks_pkg.sv */
`default_nettype none
package mks_pkg;
  // hold time before a toggle, in milliseconds
  localparam int unsigned HOLD_MS = 32'h0000_03E8;
  localparam int unsigned CLK_HZ = 32'h02FA_F080;
  localparam int unsigned MS_PER_S = 32'h0000_03E8;
  localparam int unsigned HOLD_CYCLES = (CLK_HZ / MS_PER_S) * HOLD_MS;
  // led flash half period while key is detected, in milliseconds
  localparam int unsigned FLASH_MS = 32'h0000_007D;
  localparam int unsigned FLASH_CYCLES = (CLK_HZ / MS_PER_S) * FLASH_MS;
  localparam int unsigned CNT_W = 32'h0000_0020;
  localparam logic RESET_ON = 1'b0;
  // enabled edges after reset: the strap loads at BOOT_LOAD, keys count from BOOT_DONE
  localparam int unsigned BOOT_W = 32'h0000_0002;
  localparam logic [BOOT_W-1:0] BOOT_LOAD = 2'h2;
  localparam logic [BOOT_W-1:0] BOOT_DONE = 2'h3;

  typedef enum logic [1:0] {
    MKS_IDLE,
    MKS_HOLD,
    MKS_WAIT_RELEASE
  } mks_state_type;

  // sensor pins after synchronisation
  typedef struct packed {
    logic key;
    logic attached;
  } mks_sense_type;
endpackage
`default_nettype wire

/* design/mks_power_switch.sv */
`default_nettype none
module mks_power_switch
  import mks_pkg::*;
#(
  parameter int unsigned HOLD_CNT = HOLD_CYCLES,
  parameter int unsigned FLASH_CNT = FLASH_CYCLES
)
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic key_present_i,
  input wire logic switch_attached_i,
  input wire logic stored_on_i,
  output logic system_on_o,
  output logic led_o,
  output logic store_we_o,
  output logic store_on_o
);
  import mks_pkg::*;

  // persistence lives outside the block: store_we_o pulses once per toggle
  // and store_on_o carries the state to be kept across a power loss
  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; stage one is read only by stage two
  // the key and attached pins come from the switch port, outside this clock
  // the stored state is synchronised as well, since the store may still be settling
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic stored_s1_q;
  logic stored_s2_q;
  mks_sense_type sense;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      stored_s1_q <= 1'b0;
      stored_s2_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sync1_q <= {key_present_i, switch_attached_i};
      sync2_q <= sync1_q;
      stored_s1_q <= stored_on_i;
      stored_s2_q <= stored_s1_q;
    end
  end

  assign sense = mks_sense_type'(sync2_q);

  ////////////////////////////////////////////////////////////////////////////
  // restore the remembered state once the synchronised strap is valid;
  // loading it any earlier would pick up the synchronisers' reset value
  logic [BOOT_W-1:0] boot_q;
  logic boot_done;
  logic on_q;
  logic toggle;

  // boot_q stops at BOOT_DONE and stays there until the next reset
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      boot_q <= '0;
    else if (clk_en_i && !boot_done)
      boot_q <= boot_q + BOOT_W'(1);
  end

  // presses are ignored until the state has been restored
  assign boot_done = (boot_q == BOOT_DONE);

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      on_q <= RESET_ON;
    else if (clk_en_i)
    begin
      if (boot_q == BOOT_LOAD)
        on_q <= stored_s2_q;
      else if (boot_done && toggle)
        on_q <= ~on_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold timer; a toggle fires once per press
  // only enabled edges count, so a low clock enable stretches the hold
  // the answer lags the pin by the two synchroniser stages
  mks_state_type state_q;
  logic [CNT_W-1:0] hold_q;

  assign toggle = (state_q == MKS_HOLD) && sense.key && (hold_q == CNT_W'(HOLD_CNT - 1));

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= MKS_IDLE;
      hold_q <= '0;
    end
    else if (clk_en_i)
    begin
      unique case (state_q)
        MKS_IDLE:
        begin
          hold_q <= '0;
          if (sense.key && boot_done)
            state_q <= MKS_HOLD;
        end
        MKS_HOLD:
        begin
          if (!sense.key)
          begin
            hold_q <= '0;
            state_q <= MKS_IDLE;
          end
          else if (toggle)
          begin
            hold_q <= '0;
            state_q <= MKS_WAIT_RELEASE;
          end
          else
            hold_q <= hold_q + CNT_W'(1);
        end
        MKS_WAIT_RELEASE:
        begin
          // a key left in place must not toggle again
          if (!sense.key)
            state_q <= MKS_IDLE;
        end
        default:
          state_q <= MKS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // led flash timer
  // each press starts lit, so the first flash lasts a full half period
  logic [CNT_W-1:0] flash_q;
  logic blink_q;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      flash_q <= '0;
      blink_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!sense.key)
      begin
        flash_q <= '0;
        blink_q <= 1'b1;
      end
      else if (flash_q == CNT_W'(FLASH_CNT - 1))
      begin
        flash_q <= '0;
        blink_q <= ~blink_q;
      end
      else
        flash_q <= flash_q + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs registered, one process for each
  // all outputs come from flip-flops so the pins never glitch
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      system_on_o <= 1'b0;
    else if (clk_en_i)
      // an unplugged switch cannot turn the system off
      system_on_o <= !sense.attached || on_q;
  end

  // flashing is shown only while a hold runs; once toggled the led shows the
  // state even if the key is left in place
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      led_o <= 1'b0;
    else if (clk_en_i)
    begin
      if (state_q == MKS_HOLD && sense.key)
        led_o <= blink_q;
      else
        led_o <= sense.attached && on_q;
    end
  end

  // the write strobe lasts one cycle because the state leaves MKS_HOLD on the
  // same edge that the toggle fires
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      store_we_o <= 1'b0;
    else if (clk_en_i)
      store_we_o <= toggle;
  end

  // taken with the toggle, the inverse of on_q is the state being entered
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      store_on_o <= 1'b0;
    else if (clk_en_i)
      store_on_o <= ~on_q;
  end
endmodule
`default_nettype wire

/* dv/mks_key_model.sv */
`default_nettype none
module mks_key_model (
  input wire logic clock_i,
  output logic key_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial key_o = 1'b0;
  task automatic press(input int n);
    @(posedge clock_i) key_o <= 1'b1;
    repeat (n) @(posedge clock_i);
    key_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/mks_power_switch_asserts.sv */
`default_nettype none
module mks_power_switch_asserts (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic key_present_i,
  input wire logic switch_attached_i,
  input wire logic system_on_o,
  input wire logic led_o,
  input wire logic store_we_o,
  input wire logic store_on_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_lvl; (switch_attached_i && !key_present_i)[*6] |-> led_o == system_on_o; endproperty
  a_lvl: assert property (p_lvl) else $error("led not steady");
  property p_nosw; (!switch_attached_i)[*5] |-> system_on_o; endproperty
  a_nosw: assert property (p_nosw) else $error("off while detached");
  property p_on;
    store_we_o && store_on_o |=> system_on_o && (led_o || !switch_attached_i);
  endproperty
  a_on: assert property (p_on) else $error("bad on");
  property p_off;
    store_we_o && !store_on_o |=> !led_o && (system_on_o == !switch_attached_i);
  endproperty
  a_off: assert property (p_off) else $error("bad off");
  property p_frz;
    !clk_en_i |=> $stable(system_on_o) && $stable(led_o) && $stable(store_we_o);
  endproperty
  a_frz: assert property (p_frz) else $error("moved while frozen");
  property p_store; store_we_o |=> !store_we_o; endproperty
  a_store: assert property (p_store) else $error("long store");
  property p_held; store_we_o |-> $past(key_present_i, 5); endproperty
  a_held: assert property (p_held) else $error("toggle without key");
endmodule
bind mks_power_switch mks_power_switch_asserts i_mks_power_switch_asserts (.clock_i, .nrst_i,
  .clk_en_i, .key_present_i, .switch_attached_i, .system_on_o, .led_o, .store_we_o,
  .store_on_o);
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic att = 1'b1;
  logic sto = 1'b1;
  logic en = 1'b1;
  logic key, on, led, we, son;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  mks_key_model i_mks_key_model (.clock_i(clk), .key_o(key));
  mks_power_switch #(.HOLD_CNT(20), .FLASH_CNT(4)) i_mks_power_switch (.clock_i(clk),
    .nrst_i(nrst), .clk_en_i(en), .key_present_i(key), .switch_attached_i(att),
    .stored_on_i(sto), .system_on_o(on), .led_o(led), .store_we_o(we), .store_on_o(son));
  task automatic chk(string s, logic e, logic g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // sto only changes through store writes, so a reboot shows real persistence
  task automatic boot(logic e);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk("on", e, on);
    $display("boot done");
  endtask
  task automatic hold(int n, logic e);
    logic s0 = 1'b0;
    logic s1 = 1'b0;
    fork
      i_mks_key_model.press(n);
      repeat (n) @(posedge clk) {s0, s1} = {s0 | led === 1'b0, s1 | led === 1'b1};
    join
    repeat (5) @(posedge clk);
    chk("flash", 1'b1, s0 & s1);
    chk("on", e, on);
    chk("led", e, led);
    $display("hold %0d done", n);
  endtask
  // a long press while the clock enable is low must leave the state alone
  task automatic freeze(logic e);
    en <= 1'b0;
    i_mks_key_model.press(60);
    repeat (5) @(posedge clk);
    chk("frozen", e, on);
    en <= 1'b1;
    repeat (5) @(posedge clk);
    chk("thawed", e, on);
    $display("freeze done");
  endtask
  initial
  begin
    boot(1'b1);
    hold(10, 1'b1);
    hold(12, 1'b1);
    freeze(1'b1);
    hold(60, 1'b0);
    boot(1'b0);
    hold(60, 1'b1);
    boot(1'b1);
    hold(60, 1'b0);
    att <= 1'b0;
    repeat (5) @(posedge clk);
    chk("detached", 1'b1, on);
    give_verdict();
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (we)
      sto <= son;
    if (cyc == 2000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
